// >>> tb_uac_core.sv
// self-checking bench for the serial core
`timescale 1ns/1ps
`default_nettype none
module tb_uac_core;
   logic        clk, rst, rd_en, wr_en, c8, sl, bp;
   logic [1:0]  ps;
   logic [4:0]  adr;
   logic [7:0]  d;
   logic [11:0] f;
   logic [31:0] wdat;
   wire  logic [31:0] rdat;
   wire  logic  wreq, txl, txi, rxi, pin, rxl;
   int          n, err_count, tests_run, tx_n, rx_n;
   uac_core u_uac_core (
      .core_clk_in(clk), .reset_in(rst), .avs_address_in(adr), .avs_read_in(rd_en), .avs_write_in(wr_en),
      .avs_writedata_in(wdat), .avs_readdata_out(rdat), .avs_waitrequest_out(wreq),
      .ext_baud_clock_pin_in(pin), .serial_rx_line_in(rxl), .serial_tx_out(txl),
      .tx_done_irq_out(txi), .rx_done_irq_out(rxi));
   uac_remote_node u_uac_remote_node (.serial_tx_in(txl), .ext_baud_clock_pin_out(pin), .serial_rx_line_out(rxl));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      tx_n <= tx_n + int'(txi);
      rx_n <= rx_n + int'(rxi);
   end
   function automatic logic [11:0] frame(input logic [7:0] v, input logic [1:0] p, input logic w8, bad_p, bad_s);
      logic [11:0] r;
      logic [7:0]  m;
      int          i;
      r = w8 ? {3'h7, v, 1'b0} : {4'hf, v[6:0], 1'b0};
      m = r[8:1] & {w8, 7'h7f};
      i = w8 ? 9 : 8;
      if (p != 2'b00) begin
         r[i] = (p == 2'b11 ? ^m : p == 2'b10 ? ~^m : 1'b0) ^ bad_p;
         i++;
      end
      r[i] = ~bad_s;
      return r;
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   // request held until waitrequest is seen low at an edge
   task automatic bus(input logic [4:0] a, input logic w, input logic [7:0] v, output logic [31:0] r);
      @(posedge clk);
      adr <= a;
      rd_en <= !w;
      wr_en <= w;
      wdat <= {24'h0, v};
      do begin
         @(posedge clk);
      end while (wreq !== 1'b0);
      r = rdat;
      rd_en <= 1'b0;
      wr_en <= 1'b0;
   endtask
   task automatic wr(input logic [4:0] a, input logic [7:0] v);
      logic [31:0] r;
      bus(a, 1'b1, v, r);
   endtask
   task automatic rdc(input logic [4:0] a, input logic [31:0] e, input string nm);
      logic [31:0] r;
      bus(a, 1'b0, 8'h00, r);
      chk(nm, e, r);
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      rst = 1'b1; rd_en = 1'b0; wr_en = 1'b0; adr = 5'h00; wdat = 32'h0;
      err_count = 0; tests_run = 0; tx_n = 0; rx_n = 0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      // offsets above 0x14 are unmapped and read zero
      for (int a = 0; a < 8; a++) rdc(5'(a * 4), (a == 3) ? 32'hff : 32'h0, "reset value");
      $display("test reset values done");
      wr(5'h08, 8'h80);
      for (int k = 0; k < 5; k++) begin
         ps = 2'(k); c8 = (k != 4); sl = k[0]; bp = (k != 0); d = 8'h96 ^ 8'(k);
         n = (c8 ? 10 : 9) + int'(ps != 2'b00);
         wr(5'h00, {2'b11, ps, c8, sl, 2'b00});
         fork
            u_uac_remote_node.recv(f, n + int'(sl));
            wr(5'h0c, d);
         join
         chk("tx frame", {20'h0, frame(d, ps, c8, 1'b0, 1'b0)}, {20'h0, f});
         chk("tx done irqs", k + 1, tx_n);
         rdc(5'h14, 32'h1, "pending set");
         wr(5'h14, 8'h01);
         rdc(5'h14, 32'h0, "pending clear");
         u_uac_remote_node.send(frame(d, ps, c8, bp, 1'b0), n);
         chk("rx done irqs", k + 1, rx_n);
         rdc(5'h04, {29'h0, ps[1] & bp, 2'b00}, "parity flag");
         rdc(5'h10, {24'h0, d[7] & c8, d[6:0]}, "rx data");
         rdc(5'h04, 32'h0, "flags after read");
         $display("test mode %0d done", k);
      end
      wr(5'h00, 8'hc8);
      // low stop bit runs on past the sample point, so a false start must be dropped
      u_uac_remote_node.send(frame(8'h3c, 2'b00, 1'b1, 1'b0, 1'b1), 10);
      rdc(5'h04, 32'h2, "framing flag");
      // idle line long enough for the false start check to see it high
      u_uac_remote_node.ticks(16);
      u_uac_remote_node.send(frame(8'h5a, 2'b00, 1'b1, 1'b0, 1'b0), 10);
      chk("rx irqs after glitch", 7, rx_n);
      rdc(5'h04, 32'h1, "overrun flag");
      rdc(5'h10, 32'h5a, "rx after overrun");
      $display("test errors done");
      fork
         u_uac_remote_node.send(frame(8'h81, 2'b00, 1'b1, 1'b0, 1'b0), 10);
         begin
            u_uac_remote_node.ticks(60);
            wr(5'h00, 8'h88);
         end
      join
      rdc(5'h10, 32'h5a, "rx kept on abort");
      chk("rx irqs on abort", 7, rx_n);
      $display("test abort done");
      wr(5'h0c, 8'h55);
      u_uac_remote_node.ticks(40);
      wr(5'h00, 8'h08);
      wr(5'h0c, 8'hff);
      chk("tx line after disable", 32'h1, {31'h0, txl});
      chk("tx irqs after disable", 5, tx_n);
      wr(5'h00, 8'h88);
      fork
         u_uac_remote_node.recv(f, 10);
         wr(5'h0c, 8'h3c);
      join
      chk("tx after re-enable", {20'h0, frame(8'h3c, 2'b00, 1'b1, 1'b0, 1'b0)}, {20'h0, f});
      $display("test tx disable done");
      close_out();
   end
   // whole run is near 20k cycles; this cuts a hang at 100k
   initial begin
      #1ms;
      err_count++;
      close_out();
   end
endmodule
`default_nettype wire

// >>> uac_core.v
// asynchronous serial transmit/receive core with avalon-mm register slave
`timescale 1ns/1ps
`default_nettype none
`include "uac_core_defs.vh"
module uac_core (
   input  wire        core_clk_in,
   input  wire        reset_in,
   input  wire [4:0]  avs_address_in,
   input  wire        avs_read_in,
   input  wire        avs_write_in,
   input  wire [31:0] avs_writedata_in,
   output wire [31:0] avs_readdata_out,
   output wire        avs_waitrequest_out,
   input  wire        ext_baud_clock_pin_in,
   input  wire        serial_rx_line_in,
   output wire        serial_tx_out,
   output wire        tx_done_irq_out,
   output wire        rx_done_irq_out
);
   localparam RX_IDLE  = 3'd0;
   localparam RX_START = 3'd1;
   localparam RX_DATA  = 3'd2;
   localparam RX_PAR   = 3'd3;
   localparam RX_STOP  = 3'd4;
   localparam RX_FIN   = 3'd5;

   // parity bit for a character under the given mode
   function par_bit;
      input [7:0] data;
      input [1:0] ps;
      begin
         case (ps)
            `UAC_PAR_EVEN: par_bit = ^data;
            `UAC_PAR_ODD:  par_bit = ~(^data);
            default:       par_bit = 1'b0;
         endcase
      end
   endfunction

   reg  [7:0]  mode_q;
   reg  [7:0]  baud_q;
   reg  [7:0]  txs_q;
   reg  [7:0]  rxb_q;
   reg  [2:0]  err_q;
   reg         unread_q;
   reg         tx_pend_q;
   reg  [31:0] rdata_q;
   reg         wait_q;
   reg  [2:0]  pin_sync_q;
   reg  [1:0]  rx_sync_q;
   reg  [3:0]  tx_tick_q;
   reg  [3:0]  tx_left_q;
   reg  [11:0] tx_frame_q;
   reg         tx_busy_q;
   reg         tx_line_q;
   reg         tx_irq_q;
   reg  [2:0]  rx_state_q;
   reg  [3:0]  rx_tick_q;
   reg  [3:0]  rx_bit_q;
   reg  [7:0]  rx_shift_q;
   reg         rx_par_q;
   reg         rx_irq_q;

   wire        txe      = mode_q[`UAC_TXE_BIT];
   wire        rxe      = mode_q[`UAC_RXE_BIT];
   wire [1:0]  ps       = {mode_q[`UAC_PS_HI_BIT], mode_q[`UAC_PS_LO_BIT]};
   wire        cl8      = mode_q[`UAC_CL_BIT];
   wire        sl2      = mode_q[`UAC_SL_BIT];
   wire        ext_sel  = (baud_q == `UAC_BAUD_EXT);
   // one tick per rising edge of the pin: sixteen ticks make one bit
   wire        tick     = ext_sel & pin_sync_q[1] & ~pin_sync_q[2];
   wire        rx_in    = rx_sync_q[1];
   wire        req      = avs_read_in | avs_write_in;
   // first cycle only raises the answer; effects wait for waitrequest low
   wire        ans      = req & wait_q;
   wire        acc      = req & ~wait_q;
   wire        wr_mode  = acc & avs_write_in & (avs_address_in == `UAC_OFS_MODE);
   wire        wr_baud  = acc & avs_write_in & (avs_address_in == `UAC_OFS_BAUD);
   wire        wr_txs   = acc & avs_write_in & (avs_address_in == `UAC_OFS_TXS);
   wire        wr_pend  = acc & avs_write_in & (avs_address_in == `UAC_OFS_PEND);
   wire        rd_rxb   = acc & avs_read_in & (avs_address_in == `UAC_OFS_RXB);
   wire        rx_done  = (rx_state_q == RX_STOP) & tick & (rx_tick_q == `UAC_TICKS_BIT);
   wire [7:0]  rx_data  = cl8 ? rx_shift_q : {1'b0, rx_shift_q[7:1]};
   wire [7:0]  tx_data  = cl8 ? avs_writedata_in[7:0] : {1'b0, avs_writedata_in[6:0]};
   wire        tx_par_on = (ps != `UAC_PAR_NONE);
   wire        tx_done  = tx_busy_q & tick & (tx_tick_q == `UAC_TICKS_BIT) & (tx_left_q == 4'h1);
   reg  [31:0] rdata_d;
   reg  [11:0] tx_frame_d;
   reg  [3:0]  tx_len_d;

   // pin and line synchronisers; the line is read at the second stage, the pin edge from the second and third
   always @(posedge core_clk_in) begin
      if (reset_in) begin
         pin_sync_q <= 3'h0;
         rx_sync_q  <= 2'h3;
      end else begin
         pin_sync_q <= {pin_sync_q[1:0], ext_baud_clock_pin_in};
         rx_sync_q  <= {rx_sync_q[0], serial_rx_line_in};
      end
   end

   // bus slave: one wait cycle, then the answer for one cycle
   always @* begin
      rdata_d = 32'h0;
      case (avs_address_in)
         `UAC_OFS_MODE: rdata_d = {24'h0, mode_q};
         `UAC_OFS_ERR:  rdata_d = {29'h0, err_q};
         `UAC_OFS_BAUD: rdata_d = {24'h0, baud_q};
         `UAC_OFS_TXS:  rdata_d = {24'h0, txs_q};
         `UAC_OFS_RXB:  rdata_d = {24'h0, rxb_q};
         `UAC_OFS_PEND: rdata_d = {31'h0, tx_pend_q};
         default:       rdata_d = 32'h0;
      endcase
   end

   always @(posedge core_clk_in) begin
      if (reset_in) begin
         wait_q  <= 1'b1;
         rdata_q <= 32'h0;
         mode_q  <= `UAC_MODE_RST;
         baud_q  <= `UAC_BAUD_RST;
      end else begin
         wait_q <= ~ans;
         if (ans & avs_read_in)
            rdata_q <= rdata_d;
         // low two bits are fixed at zero; mode changes mid-frame are on software
         if (wr_mode)
            mode_q <= {avs_writedata_in[7:2], 2'b00};
         if (wr_baud)
            baud_q <= {avs_writedata_in[7:4], 4'h0};
      end
   end

   // transmit frame builder: lsb first, start bit in bit 0
   always @* begin
      tx_frame_d = 12'hfff;
      tx_len_d   = 4'h0;
      if (cl8) begin
         tx_frame_d[8:0] = {tx_data, 1'b0};
         if (tx_par_on)
            tx_frame_d[9] = par_bit(tx_data, ps);
         tx_len_d = 4'h9;
      end else begin
         tx_frame_d[7:0] = {tx_data[6:0], 1'b0};
         if (tx_par_on)
            tx_frame_d[8] = par_bit(tx_data, ps);
         tx_len_d = 4'h8;
      end
      tx_len_d = tx_len_d + (tx_par_on ? 4'h1 : 4'h0) + (sl2 ? 4'h2 : 4'h1);
   end

   always @(posedge core_clk_in) begin
      if (reset_in) begin
         txs_q      <= 8'hff;
         tx_busy_q  <= 1'b0;
         tx_tick_q  <= 4'h0;
         tx_left_q  <= 4'h0;
         tx_frame_q <= 12'hfff;
         tx_line_q  <= 1'b1;
         tx_irq_q   <= 1'b0;
         tx_pend_q  <= 1'b0;
      end else begin
         tx_irq_q <= tx_done;
         if (wr_txs)
            txs_q <= avs_writedata_in[7:0];
         if (~txe) begin
            // disabling aborts the frame and idles the line
            tx_busy_q <= 1'b0;
            tx_line_q <= 1'b1;
         end else if (wr_txs & ~tx_busy_q) begin
            tx_busy_q  <= 1'b1;
            tx_frame_q <= tx_frame_d;
            tx_left_q  <= tx_len_d;
            tx_tick_q  <= 4'h0;
            tx_line_q  <= 1'b0;
         end else if (tx_busy_q & tick) begin
            tx_tick_q <= tx_tick_q + 4'h1;
            if (tx_tick_q == `UAC_TICKS_BIT) begin
               tx_frame_q <= {1'b1, tx_frame_q[11:1]};
               tx_left_q  <= tx_left_q - 4'h1;
               tx_line_q  <= tx_frame_q[1];
               if (tx_left_q == 4'h1) begin
                  tx_busy_q <= 1'b0;
                  tx_line_q <= 1'b1;
               end
            end
         end
         // set wins over a clear in the same cycle
         if (tx_done)
            tx_pend_q <= 1'b1;
         else if (wr_pend & avs_writedata_in[`UAC_PEND_TX_BIT])
            tx_pend_q <= 1'b0;
      end
   end

   // receiver
   always @(posedge core_clk_in) begin
      if (reset_in) begin
         rx_state_q <= RX_IDLE;
         rx_tick_q  <= 4'h0;
         rx_bit_q   <= 4'h0;
         rx_shift_q <= 8'h0;
         rx_par_q   <= 1'b0;
         rx_irq_q   <= 1'b0;
      end else begin
         rx_irq_q <= 1'b0;
         if (~rxe) begin
            rx_state_q <= RX_IDLE;
         end else begin
            case (rx_state_q)
               RX_IDLE: begin
                  rx_tick_q <= 4'h0;
                  if (tick & ~rx_in)
                     rx_state_q <= RX_START;
               end
               RX_START: if (tick) begin
                  rx_tick_q <= rx_tick_q + 4'h1;
                  if (rx_tick_q[2:0] == `UAC_TICKS_HALF) begin
                     rx_tick_q <= 4'h0;
                     rx_bit_q  <= 4'h0;
                     rx_par_q  <= 1'b0;
                     rx_state_q <= rx_in ? RX_IDLE : RX_DATA;
                  end
               end
               RX_DATA: if (tick) begin
                  rx_tick_q <= rx_tick_q + 4'h1;
                  if (rx_tick_q == `UAC_TICKS_BIT) begin
                     rx_shift_q <= {rx_in, rx_shift_q[7:1]};
                     rx_par_q   <= rx_par_q ^ rx_in;
                     rx_bit_q   <= rx_bit_q + 4'h1;
                     if (rx_bit_q == (cl8 ? 4'h7 : 4'h6))
                        rx_state_q <= (ps == `UAC_PAR_NONE) ? RX_STOP : RX_PAR;
                  end
               end
               RX_PAR: if (tick) begin
                  rx_tick_q <= rx_tick_q + 4'h1;
                  if (rx_tick_q == `UAC_TICKS_BIT) begin
                     rx_par_q   <= rx_par_q ^ rx_in;
                     rx_state_q <= RX_STOP;
                  end
               end
               RX_STOP: if (tick) begin
                  rx_tick_q <= rx_tick_q + 4'h1;
                  if (rx_tick_q == `UAC_TICKS_BIT) begin
                     // one stop bit ends the frame even with two configured
                     rx_state_q <= RX_FIN;
                  end
               end
               RX_FIN: if (tick) begin
                  // buffer already updated; irq only if still enabled here
                  rx_irq_q   <= 1'b1;
                  rx_state_q <= RX_IDLE;
               end
               default: rx_state_q <= RX_IDLE;
            endcase
         end
      end
   end

   // buffer and error status: frame completion wins over a read in the same cycle
   always @(posedge core_clk_in) begin
      if (reset_in) begin
         rxb_q    <= 8'h0;
         err_q    <= 3'h0;
         unread_q <= 1'b0;
      end else if (rx_done & rxe) begin
         rxb_q    <= rx_data;
         unread_q <= 1'b1;
         err_q[`UAC_ERR_PE_BIT]  <= ((ps == `UAC_PAR_EVEN) & rx_par_q) |
                                    ((ps == `UAC_PAR_ODD) & ~rx_par_q);
         err_q[`UAC_ERR_FE_BIT]  <= ~rx_in;
         err_q[`UAC_ERR_OVE_BIT] <= unread_q & ~rd_rxb;
      end else if (rd_rxb) begin
         err_q    <= 3'h0;
         unread_q <= 1'b0;
      end
   end

   assign avs_readdata_out    = rdata_q;
   assign avs_waitrequest_out = wait_q;
   assign serial_tx_out       = tx_line_q;
   assign tx_done_irq_out     = tx_irq_q;
   assign rx_done_irq_out     = rx_irq_q;
endmodule
`default_nettype wire

// >>> uac_core_checker.sv
// port-level assertions for the serial core
`timescale 1ns/1ps
`default_nettype none
module uac_core_checker (
   input wire logic        core_clk_in,
   input wire logic        reset_in,
   input wire logic        avs_read_in,
   input wire logic        avs_write_in,
   input wire logic [31:0] avs_readdata_out,
   input wire logic        avs_waitrequest_out,
   input wire logic        serial_tx_out,
   input wire logic        tx_done_irq_out,
   input wire logic        rx_done_irq_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (reset_in);
   bus_answer_a:
      assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out |=> !avs_waitrequest_out)
      else $error("bus answer late");
   one_wait_a:
      assert property (!avs_waitrequest_out |=> avs_waitrequest_out) else $error("answer held too long");
   reset_state_a:
      assert property (disable iff (1'b0) reset_in |=> avs_waitrequest_out && serial_tx_out && !tx_done_irq_out
         && !rx_done_irq_out) else $error("bad state in reset");
   upper_zero_a:
      assert property (!avs_waitrequest_out |-> avs_readdata_out[31:8] == 24'h0) else $error("upper read bits set");
   tx_pulse_a:
      assert property (tx_done_irq_out |=> !tx_done_irq_out) else $error("tx done not a pulse");
   rx_pulse_a:
      assert property (rx_done_irq_out |=> !rx_done_irq_out) else $error("rx done not a pulse");
   tx_idle_done_a:
      assert property (tx_done_irq_out |-> serial_tx_out && $stable(serial_tx_out)) else $error("tx done mid frame");
   start_hold_a:
      assert property ($fell(serial_tx_out) |=> !serial_tx_out [*8]) else $error("start bit too short");
endmodule
bind uac_core uac_core_checker u_uac_core_checker (
   .core_clk_in(core_clk_in), .reset_in(reset_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
   .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
   .serial_tx_out(serial_tx_out), .tx_done_irq_out(tx_done_irq_out), .rx_done_irq_out(rx_done_irq_out)
);
`default_nettype wire

// >>> uac_core_defs.vh
// constants for the asynchronous serial core
// Function
// - external pin clock divided by 16 gives bitrate
// - start, 7/8 data, optional parity, 1/2 stops
// - 7-bit mode: bit7 ignored, read as zero
// - even parity generated and checked
// - odd parity generated and checked
// - zero parity sent, never checked
// - no parity: none sent, none checked
// - write to tx shift register starts frame
// - tx done request after last bit shifted
// - tx done sets pollable pending flag
// - receive enable gates sampling on bit clock
// - low line, half bit, recheck, accept start
// - reception ends after one stop bit
// - frame end loads buffer, raises rx done
// - clearing receive enable aborts without effects
// - parity, framing, overrun flags after reception
// - buffer read or next frame clears flags
// - late receive disable: buffer kept/updated, no irq
// - parity field 00 none 01 zero 10 odd 11 even
`ifndef UAC_CORE_DEFS_VH
`define UAC_CORE_DEFS_VH
`define UAC_OFS_MODE     5'h00
`define UAC_OFS_ERR      5'h04
`define UAC_OFS_BAUD     5'h08
`define UAC_OFS_TXS      5'h0c
`define UAC_OFS_RXB      5'h10
`define UAC_OFS_PEND     5'h14
`define UAC_MODE_RST     8'h00
`define UAC_BAUD_RST     8'h00
`define UAC_BAUD_EXT     8'h80
`define UAC_TXE_BIT      7
`define UAC_RXE_BIT      6
`define UAC_PS_HI_BIT    5
`define UAC_PS_LO_BIT    4
`define UAC_CL_BIT       3
`define UAC_SL_BIT       2
`define UAC_PAR_NONE     2'b00
`define UAC_PAR_ZERO     2'b01
`define UAC_PAR_ODD      2'b10
`define UAC_PAR_EVEN     2'b11
`define UAC_ERR_PE_BIT   2
`define UAC_ERR_FE_BIT   1
`define UAC_ERR_OVE_BIT  0
`define UAC_PEND_TX_BIT  0
`define UAC_TICKS_BIT    4'hf
`define UAC_TICKS_HALF   3'h7
`endif

// >>> uac_remote_node.sv
// remote serial node: bit clock pin source, frame sender and receiver
`timescale 1ns/1ps
`default_nettype none
module uac_remote_node (
   input  wire logic serial_tx_in,
   output var  logic ext_baud_clock_pin_out,
   output var  logic serial_rx_line_out
);
   // pin runs free, 8 core cycles a period, halves above the 3-cycle minimum
   initial begin
      ext_baud_clock_pin_out = 1'b0;
      serial_rx_line_out = 1'b1;
      forever #40 ext_baud_clock_pin_out = ~ext_baud_clock_pin_out;
   end
   task automatic ticks(input int n);
      repeat (n) @(posedge ext_baud_clock_pin_out);
   endtask
   // lsb first, 16 pin periods a bit, line back to idle high
   task automatic send(input logic [11:0] f, input int n);
      for (int i = 0; i < n; i++) begin
         serial_rx_line_out = f[i];
         ticks(16);
      end
      serial_rx_line_out = 1'b1;
   endtask
   // samples mid-bit, returns half a bit past the last stop
   task automatic recv(output logic [11:0] f, input int n);
      f = 12'hfff;
      @(negedge serial_tx_in);
      ticks(8);
      for (int i = 0; i < n; i++) begin
         f[i] = serial_tx_in;
         ticks(16);
      end
   endtask
endmodule
`default_nettype wire
